/* File: inc/can_filter_pkg.sv */
// constants shared by the acceptance filter bank: map, field layout, reset values
package can_filter_pkg;

	// ==========================================================================
	// register map (byte addresses on the 8-bit register port)
	// ==========================================================================
	localparam int unsigned       NUM_FILTERS       = 6;
	localparam int unsigned       BANK_BYTES        = 8;
	localparam int unsigned       BANK_DEPTH        = NUM_FILTERS * BANK_BYTES;
	localparam logic [7:0]        BANK_BASE_ADDR    = 8'h00;  // filter f byte k at f*8+k
	localparam logic [7:0]        BANK_LAST_ADDR    = 8'h2F;
	localparam logic [7:0]        CONFIG0_ADDR      = 8'h30;  // filters 0 and 1
	localparam logic [7:0]        CONFIG1_ADDR      = 8'h31;  // filters 2 and 3
	localparam logic [7:0]        CONFIG2_ADDR      = 8'h32;  // filters 4 and 5
	localparam logic [7:0]        MODE_LOWER_ADDR   = 8'h33;  // filters 0..3
	localparam logic [7:0]        MODE_UPPER_ADDR   = 8'h34;  // filters 4 and 5

	// ==========================================================================
	// field layout and reset values
	// ==========================================================================
	localparam logic [7:0]        MODE_UPPER_RESET  = 8'h00;
	localparam logic [7:0]        MODE_LOWER_RESET  = 8'h00;
	localparam logic [7:0]        CONFIG_RESET      = 8'h00;
	localparam logic [7:0]        MODE_UPPER_MASK   = 8'h0F;  // bits 7:4 read as zero
	localparam logic [7:0]        CONFIG_MASK       = 8'h77;  // bits 7 and 3 read as zero
	localparam int unsigned       MODE_F4_LOW_BIT   = 0;
	localparam int unsigned       MODE_F4_HIGH_BIT  = 1;
	localparam int unsigned       MODE_F5_LOW_BIT   = 2;
	localparam int unsigned       MODE_F5_HIGH_BIT  = 3;
	localparam int unsigned       CFG_NIBBLE        = 4;      // second filter of a pair
	localparam int unsigned       CFG_ACTIVE_BIT    = 0;
	localparam int unsigned       CFG_SCALE_MSB     = 2;
	localparam logic [1:0]        SCALE_8BIT        = 2'b00;
	localparam logic [1:0]        SCALE_16BIT       = 2'b01;
	localparam logic [7:0]        READ_IDLE         = 8'h00;

endpackage : can_filter_pkg

/* File: verilog/can_acceptance_filter_bank.sv */
// acceptance filter bank: mode/config registers, pattern bytes and identifier comparison
//
// Function
// R1: upper mode bits 7:4 read zero, ignore writes
// R2: upper mode resets zero, software owns it
// R3: bit 3 selects filter 5 high half mode
// R4: bit 2 selects filter 5 low half mode
// R5: bit 1 selects filter 4 high half mode
// R6: bit 0 selects filter 4 low half mode
// R7: each filter holds eight 8-bit pattern bytes
// R8: identifier bit zero dominant, one recessive
// R9: mask bit zero makes identifier bit don't-care
// R10: mask bit one demands equal incoming bit
// R11: scale and mode assign byte roles
// R12: mask bytes map bits like list mode
// R13: software deactivates filter before writing bytes
// R14: filter banks placed in pairs 0:1, 2:3, 4:5
// R15: activation bit enables filter in acceptance
// R16: software in init mode before scale change
// R17: pattern bytes need no reset value
// R18: list mode accepts only exact listed identifiers
`timescale 1ns/1ps

module can_acceptance_filter_bank (
	// clock and reset
	input  wire logic        clock_in,
	input  wire logic        reset_n_in,
	// register port
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [7:0]  reg_wdata_in,
	input  wire logic        reg_write_in,
	input  wire logic        reg_read_in,
	output logic      [7:0]  reg_rdata_out,
	// identifier from the receive path
	input  wire logic        id_valid_in,
	input  wire logic [31:0] id_in,
	// acceptance result
	output logic             result_valid_out,
	output logic             accept_out,
	output logic      [5:0]  filter_hit_out
);

	// ==========================================================================
	// storage
	// ==========================================================================
	logic [7:0]  bank_r [can_filter_pkg::BANK_DEPTH];
	logic [7:0]  config_r [3];
	logic [7:0]  mode_lower_r;
	logic [3:0]  mode_upper_r;
	logic [7:0]  rdata_r;
	logic        result_valid_r;
	logic        accept_r;
	logic [5:0]  hit_r;

	// ==========================================================================
	// address decode
	// ==========================================================================
	wire logic       bank_sel    = (reg_addr_in <= can_filter_pkg::BANK_LAST_ADDR);
	wire logic [5:0] bank_idx    = reg_addr_in[5:0];
	wire logic       cfg0_sel    = (reg_addr_in == can_filter_pkg::CONFIG0_ADDR);
	wire logic       cfg1_sel    = (reg_addr_in == can_filter_pkg::CONFIG1_ADDR);
	wire logic       cfg2_sel    = (reg_addr_in == can_filter_pkg::CONFIG2_ADDR);
	wire logic       lower_sel   = (reg_addr_in == can_filter_pkg::MODE_LOWER_ADDR);
	wire logic       upper_sel   = (reg_addr_in == can_filter_pkg::MODE_UPPER_ADDR);

	// mode select bits of filters 4 and 5, one per half
	wire logic filter4_low_half_list_sel  = mode_upper_r[can_filter_pkg::MODE_F4_LOW_BIT]; // [R6]
	wire logic filter4_high_half_list_sel = mode_upper_r[can_filter_pkg::MODE_F4_HIGH_BIT]; // [R5]
	wire logic filter5_low_half_list_sel  = mode_upper_r[can_filter_pkg::MODE_F5_LOW_BIT]; // [R4]
	wire logic filter5_high_half_list_sel = mode_upper_r[can_filter_pkg::MODE_F5_HIGH_BIT]; // [R3]

	// all twelve half-mode bits: filter f low half at bit 2f, high half at 2f+1
	wire logic [11:0] list_sel_all = {filter5_high_half_list_sel, filter5_low_half_list_sel,
	                                  filter4_high_half_list_sel, filter4_low_half_list_sel,
	                                  mode_lower_r};

	// read mux; unmapped addresses answer zero
	logic [7:0] rdata_nxt;
	always_comb begin
		if (bank_sel)
			rdata_nxt = bank_r[bank_idx];
		else if (cfg0_sel)
			rdata_nxt = config_r[0];
		else if (cfg1_sel)
			rdata_nxt = config_r[1];
		else if (cfg2_sel)
			rdata_nxt = config_r[2];
		else if (lower_sel)
			rdata_nxt = mode_lower_r;
		else if (upper_sel)
			rdata_nxt = {4'h0, mode_upper_r};  // [R1]
		else
			rdata_nxt = can_filter_pkg::READ_IDLE;
	end

	// ==========================================================================
	// register writes
	// ==========================================================================
	// pattern bytes carry no reset: they are meaningless until software loads them,
	// and leaving them unreset keeps the array flop-cheap
	always_ff @(posedge clock_in) begin
		if (reg_write_in && bank_sel)
			bank_r[bank_idx] <= reg_wdata_in;  // [R7] [R14] [R17]
	end

	// configuration and mode; writes to a filter while it is active are not blocked,
	// so software must deactivate first or it races a comparison in flight
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			config_r[0]  <= can_filter_pkg::CONFIG_RESET;
			config_r[1]  <= can_filter_pkg::CONFIG_RESET;
			config_r[2]  <= can_filter_pkg::CONFIG_RESET;
			mode_lower_r <= can_filter_pkg::MODE_LOWER_RESET;
			mode_upper_r <= can_filter_pkg::MODE_UPPER_RESET[3:0];  // [R2]
		end else if (reg_write_in) begin
			if (cfg0_sel)
				config_r[0] <= reg_wdata_in & can_filter_pkg::CONFIG_MASK;
			if (cfg1_sel)
				config_r[1] <= reg_wdata_in & can_filter_pkg::CONFIG_MASK;
			if (cfg2_sel)
				config_r[2] <= reg_wdata_in & can_filter_pkg::CONFIG_MASK;
			if (lower_sel)
				mode_lower_r <= reg_wdata_in;
			if (upper_sel)
				mode_upper_r <= reg_wdata_in[3:0];  // [R1] [R2]
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clock_in) begin
		if (!reset_n_in)
			rdata_r <= can_filter_pkg::READ_IDLE;
		else
			rdata_r <= reg_read_in ? rdata_nxt : can_filter_pkg::READ_IDLE;
	end

	// ==========================================================================
	// comparison helpers
	// ==========================================================================
	// a bit takes part only where the mask holds one; identifier bits are bus levels,
	// zero dominant and one recessive, compared as plain values
	function automatic logic masked_eq16(input logic [15:0] id, input logic [15:0] ref_v,
	                                     input logic [15:0] mask);
		masked_eq16 = ((id ^ ref_v) & mask) == 16'h0000;  // [R8] [R9] [R10]
	endfunction : masked_eq16

	// one identifier/mask byte pair of the 8-bit scale
	function automatic logic masked_eq8(input logic [7:0] id, input logic [7:0] ref_v, input logic [7:0] mask);
		masked_eq8 = ((id ^ ref_v) & mask) == 8'h00;  // [R9] [R10]
	endfunction : masked_eq8

	// one half filter: four bytes r0..r3 (r0 in bits 31:24) against id[31:16];
	// mask bytes sit at the same bit positions as list entries would
	function automatic logic half_hit(input logic [31:0] regs, input logic [15:0] idh,
	                                  input logic lst, input logic wide);
		logic [7:0] idb;
		idb = idh[15:8];
		if (wide) begin
			if (lst)
				half_hit = (idh == regs[31:16]) || (idh == regs[15:0]);  // [R18]
			else
				half_hit = masked_eq16(idh, regs[31:16], regs[15:0]);  // [R12]
		end else begin
			if (lst)
				half_hit = (idb == regs[31:24]) || (idb == regs[23:16]) ||
				           (idb == regs[15:8]) || (idb == regs[7:0]);  // [R18]
			else
				// two independent id/mask pairs: either one may take the identifier
				half_hit = masked_eq8(idb, regs[31:24], regs[23:16]) ||
				           masked_eq8(idb, regs[15:8], regs[7:0]);  // [R12]
		end
	endfunction : half_hit

	// ==========================================================================
	// per-filter match
	// ==========================================================================
	logic [5:0] hit_nxt;
	logic [5:0] active_vec;

	// byte roles per scale (byte k of filter f is pattern byte 8f+k):
	//   8-bit  : each half holds two id/mask pairs, or four listed ids in list mode
	//   16-bit : each half holds one id word and one mask word, or two listed words
	//   32-bit : bytes 0..3 are the id and bytes 4..7 its mask, or two listed ids
	// in 8- and 16-bit scale a filter hits when either half hits; 32-bit scale merges the halves into one 32-bit
	// masked compare, or two 32-bit list compares, so only the smaller scales are a plain OR of small comparators
	genvar f;
	generate
		for (f = 0; f < 6; f++) begin : g_filter
			localparam int unsigned CR  = f / 2;
			localparam int unsigned NB  = (f % 2) * can_filter_pkg::CFG_NIBBLE;
			wire logic        active  = config_r[CR][NB + can_filter_pkg::CFG_ACTIVE_BIT];
			wire logic [1:0]  scale   = config_r[CR][NB + can_filter_pkg::CFG_SCALE_MSB -: 2];
			wire logic        lst_lo  = list_sel_all[2 * f];
			wire logic        lst_hi  = list_sel_all[2 * f + 1];
			wire logic [31:0] lo_regs = {bank_r[8 * f], bank_r[8 * f + 1],
			                             bank_r[8 * f + 2], bank_r[8 * f + 3]};
			wire logic [31:0] hi_regs = {bank_r[8 * f + 4], bank_r[8 * f + 5],
			                             bank_r[8 * f + 6], bank_r[8 * f + 7]};
			wire logic        is_32   = (scale != can_filter_pkg::SCALE_8BIT) &&
			                            (scale != can_filter_pkg::SCALE_16BIT);
			wire logic        is_16   = (scale == can_filter_pkg::SCALE_16BIT);
			// 32-bit scale: low-half mode bit rules the whole filter
			wire logic        full_hit = lst_lo ?
			                             ((id_in == lo_regs) || (id_in == hi_regs)) :  // [R18]
			                             (((id_in ^ lo_regs) & hi_regs) == 32'h0000_0000);  // [R10]
			wire logic        split_hit = half_hit(lo_regs, id_in[31:16], lst_lo, is_16) ||
			                              half_hit(hi_regs, id_in[31:16], lst_hi, is_16);
			// scale and mode decide which bytes act as identifier and which as mask
			assign hit_nxt[f]  = active && (is_32 ? full_hit : split_hit);  // [R11] [R15]
			assign active_vec[f] = active;
		end
	endgenerate

	// ==========================================================================
	// result register: answer one cycle after the identifier is offered
	// ==========================================================================
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			result_valid_r <= 1'b0;
			accept_r       <= 1'b0;
			hit_r          <= 6'h00;
		end else begin
			result_valid_r <= id_valid_in;
			accept_r       <= id_valid_in && (|hit_nxt);  // [R15] [R18]
			hit_r          <= id_valid_in ? hit_nxt : 6'h00;
		end
	end

	assign reg_rdata_out    = rdata_r;
	assign result_valid_out = result_valid_r;
	assign accept_out       = accept_r;
	assign filter_hit_out   = hit_r;

	// ==========================================================================
	// assertions
	// ==========================================================================
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);

	sequence s_bank_write;
		reg_write_in && bank_sel;
	endsequence

	sequence s_same_read(logic [7:0] a);
		reg_read_in && !reg_write_in && (reg_addr_in == a);
	endsequence

	a_upper_reserved_zero: assert property ( // [R1]
		reg_read_in && upper_sel |=> reg_rdata_out[7:4] == 4'h0)
		else $error("upper mode reserved bits not zero");

	a_upper_after_reset: assert property ( // [R2]
		!$past(reset_n_in) |-> mode_upper_r == 4'h0)
		else $error("upper mode not cleared by reset");

	a_upper_write_load: assert property ( // [R3] [R4] [R5] [R6]
		reg_write_in && upper_sel |=> {4'h0, filter5_high_half_list_sel, filter5_low_half_list_sel,
		filter4_high_half_list_sel, filter4_low_half_list_sel} ==
		($past(reg_wdata_in) & can_filter_pkg::MODE_UPPER_MASK))
		else $error("upper mode bits did not take write data");

	a_upper_hold: assert property ( // [R2]
		!(reg_write_in && upper_sel) |=> $stable(mode_upper_r))
		else $error("upper mode changed without a write");

	property p_bank_readback;
		logic [7:0] a;
		logic [7:0] d;
		(s_bank_write, a = reg_addr_in, d = reg_wdata_in) ##1 s_same_read(a) |=> reg_rdata_out == d;
	endproperty
	a_bank_readback: assert property (p_bank_readback) // [R7]
		else $error("pattern byte readback mismatch");

	a_inactive_no_hit: assert property ( // [R15]
		result_valid_out |-> (filter_hit_out & ~$past(active_vec)) == 6'h00)
		else $error("inactive filter reported a hit");

	a_result_timing: assert property ( // [R11]
		id_valid_in |=> result_valid_out ##1 (result_valid_out == $past(id_valid_in)))
		else $error("result not one cycle after identifier");

	a_accept_or_hits: assert property ( // [R10] [R18]
		accept_out == (result_valid_out && (filter_hit_out != 6'h00)))
		else $error("accept disagrees with filter hits");

	a_unmapped_zero: assert property ( // [R14]
		reg_read_in && !bank_sel && !cfg0_sel && !cfg1_sel && !cfg2_sel && !lower_sel &&
		!upper_sel |=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");

	a_upper_readback: assert property ( // [R2]
		reg_read_in && upper_sel |=> reg_rdata_out == {4'h0, $past(mode_upper_r)})
		else $error("upper mode readback differs from register");

	// read data must fall back to idle, or a stale byte could pass for a fresh read
	a_rdata_idle: assert property ( // [R14]
		!reg_read_in |=> reg_rdata_out == can_filter_pkg::READ_IDLE)
		else $error("read data stood without a read strobe");

	a_quiet_no_hit: assert property ( // [R15]
		!result_valid_out |-> filter_hit_out == 6'h00 && !accept_out)
		else $error("hit or accept shown without a result");

	// independent views of the expected answers of filters 4 and 5, built straight
	// from the pattern bytes and the offered identifier
	wire logic [7:0]  chk_b0     = id_in[31:24];
	wire logic [15:0] chk_h0     = id_in[31:16];
	wire logic [31:0] chk_lo4    = g_filter[4].lo_regs;
	wire logic [31:0] chk_hi4    = g_filter[4].hi_regs;
	wire logic        f4_byte_ok = (((chk_b0 ^ chk_lo4[31:24]) & chk_lo4[23:16]) == 8'h00) ||
	                               (((chk_b0 ^ chk_lo4[15:8]) & chk_lo4[7:0]) == 8'h00) ||
	                               (((chk_b0 ^ chk_hi4[31:24]) & chk_hi4[23:16]) == 8'h00) ||
	                               (((chk_b0 ^ chk_hi4[15:8]) & chk_hi4[7:0]) == 8'h00);
	wire logic        f4_half_ok = (((chk_h0 ^ chk_lo4[31:16]) & chk_lo4[15:0]) == 16'h0000) ||
	                               (((chk_h0 ^ chk_hi4[31:16]) & chk_hi4[15:0]) == 16'h0000);
	wire logic        f5_list_ok = (id_in == g_filter[5].lo_regs) || (id_in == g_filter[5].hi_regs);

	// offers that reach a known configuration of filter 4 or 5
	sequence s_f4_byte_mask;
		id_valid_in && g_filter[4].active && (g_filter[4].scale == can_filter_pkg::SCALE_8BIT) &&
		!filter4_low_half_list_sel && !filter4_high_half_list_sel;
	endsequence

	sequence s_f4_half_mask;
		id_valid_in && g_filter[4].active && (g_filter[4].scale == can_filter_pkg::SCALE_16BIT) &&
		!filter4_low_half_list_sel && !filter4_high_half_list_sel;
	endsequence

	sequence s_f5_wide_list;
		id_valid_in && g_filter[5].active && g_filter[5].is_32 && filter5_low_half_list_sel;
	endsequence

	// the pairs of the 8-bit scale are alternatives, never a joint condition
	a_byte_mask_pairs: assert property ( // [R9] [R10]
		s_f4_byte_mask |=> filter_hit_out[4] == $past(f4_byte_ok))
		else $error("8-bit mask match of filter 4 wrong");

	a_half_mask_match: assert property ( // [R10] [R12]
		s_f4_half_mask |=> filter_hit_out[4] == $past(f4_half_ok))
		else $error("16-bit mask match of filter 4 wrong");

	a_wide_list_exact: assert property ( // [R18]
		s_f5_wide_list |=> filter_hit_out[5] == $past(f5_list_ok))
		else $error("32-bit list match of filter 5 wrong");

endmodule : can_acceptance_filter_bank

/* File: tb/can_id_source_model.sv */
// identifier source model standing in for the controller receive path
`timescale 1ns/1ps

module can_id_source_model (
	// clock and reset
	input  wire logic        clock_in,
	input  wire logic        reset_n_in,
	// request from the bench
	input  wire logic        send_in,
	input  wire logic [31:0] word_in,
	// identifier towards the filter bank
	output logic             id_valid_out,
	output logic      [31:0] id_out
);
	// one-cycle offer; between offers the word is inverted so a stale id never matches by luck
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			id_valid_out <= 1'b0;
			id_out       <= 32'h00000000;
		end else begin
			id_valid_out <= send_in;
			id_out       <= send_in ? word_in : ~id_out;
		end
	end
endmodule : can_id_source_model

/* File: tb/can_acceptance_filter_bank_tb.sv */
// self-checking bench for the acceptance filter bank
`timescale 1ns/1ps

module can_acceptance_filter_bank_tb;
	// ==========================================================================
	// signals
	// ==========================================================================
	logic        clock_in, reset_n_in, reg_write_in, reg_read_in, send, id_valid;
	logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out;
	logic [31:0] word, id_word;
	logic        result_valid_out, accept_out;
	logic [5:0]  filter_hit_out;
	logic [7:0]  pat [8];
	int          fail_count, compares;

	can_acceptance_filter_bank can_acceptance_filter_bank_inst (
		.clock_in(clock_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
		.reg_rdata_out(reg_rdata_out), .id_valid_in(id_valid), .id_in(id_word),
		.result_valid_out(result_valid_out), .accept_out(accept_out), .filter_hit_out(filter_hit_out));

	can_id_source_model can_id_source_model_inst (
		.clock_in(clock_in), .reset_n_in(reset_n_in), .send_in(send), .word_in(word),
		.id_valid_out(id_valid), .id_out(id_word));

	// ==========================================================================
	// clock, checks and bus tasks
	// ==========================================================================
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		reg_write_in <= 1'b1;
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		@(posedge clock_in);
		reg_write_in <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the strobe, so it is sampled just there
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock_in);
		reg_read_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clock_in);
		reg_read_in <= 1'b0;
		#1;
		chk("rdata", {24'h000000, exp}, {24'h000000, reg_rdata_out});
	endtask : rd

	task automatic send_id(input logic [31:0] w, input logic [5:0] exp_hit);
		@(posedge clock_in);
		send <= 1'b1;
		word <= w;
		@(posedge clock_in);
		send <= 1'b0;
		@(posedge clock_in);
		#1;
		chk("hits", {26'h0, exp_hit}, {26'h0, filter_hit_out});
		chk("valid accept", {30'h0, 1'b1, |exp_hit}, {30'h0, result_valid_out, accept_out});
	endtask : send_id

	// write then read the same byte with no gap between the two strobes
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		reg_write_in <= 1'b1;
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		@(posedge clock_in);
		reg_write_in <= 1'b0;
		reg_read_in  <= 1'b1;
		@(posedge clock_in);
		reg_read_in <= 1'b0;
		#1;
		chk("rdata back to back", {24'h000000, d}, {24'h000000, reg_rdata_out});
	endtask : wr_rd

	// expected hit of one half in 8-bit scale: list compares four bytes, mask uses id/mask pairs
	function automatic logic hit(input logic hi, input logic lst, input logic [7:0] b);
		int base;
		base = hi ? 4 : 0;
		if (lst)
			return (b == pat[base]) || (b == pat[base+1]) || (b == pat[base+2]) || (b == pat[base+3]);
		return (((b ^ pat[base]) & pat[base+1]) == 8'h00) || (((b ^ pat[base+2]) & pat[base+3]) == 8'h00);
	endfunction : hit

	// expected hit of a filter in 16-bit (wide=0) or 32-bit scale (wide=1); lst is {high, low} mode
	function automatic logic hit_wide(input logic wide, input logic [1:0] lst, input logic [31:0] w);
		logic [31:0] lo, hi;
		logic        lo_ok, hi_ok;
		lo = {pat[0], pat[1], pat[2], pat[3]};
		hi = {pat[4], pat[5], pat[6], pat[7]};
		if (wide)
			return lst[0] ? (w == lo || w == hi) : (((w ^ lo) & hi) == 32'h00000000);
		lo_ok = lst[0] ? (w[31:16] == lo[31:16] || w[31:16] == lo[15:0]) :
		                 (((w[31:16] ^ lo[31:16]) & lo[15:0]) == 16'h0000);
		hi_ok = lst[1] ? (w[31:16] == hi[31:16] || w[31:16] == hi[15:0]) :
		                 (((w[31:16] ^ hi[31:16]) & hi[15:0]) == 16'h0000);
		return lo_ok || hi_ok;
	endfunction : hit_wide

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict

	// ==========================================================================
	// tests
	// ==========================================================================
	initial begin
		logic [31:0] ids [5];
		logic [7:0] cfgs [4];
		logic [3:0] mv;
		logic       h4, h5;
		reset_n_in   = 1'b0;
		reg_write_in = 1'b0;
		reg_read_in  = 1'b0;
		reg_addr_in  = 8'h00;
		reg_wdata_in = 8'h00;
		send         = 1'b0;
		word         = 32'h00000000;
		fail_count   = 0;
		compares     = 0;
		pat  = '{8'h5A, 8'hF0, 8'h33, 8'hFF, 8'h11, 8'hFF, 8'h22, 8'hFF};
		ids  = '{32'h5AF033FF, 32'h11FF22FF, 32'h56F033FF, 32'h33FF0000, 32'h00000000};
		// 8-bit scale in the first three; the last sets filter 4 to 16-bit and filter 5 to 32-bit
		cfgs = '{8'h11, 8'h01, 8'h10, 8'h53};
		repeat (20) @(posedge clock_in);
		reset_n_in <= 1'b1;
		rd(can_filter_pkg::MODE_UPPER_ADDR, can_filter_pkg::MODE_UPPER_RESET);
		@(posedge clock_in);
		#1 chk("rdata idle", 32'h00000000, {24'h000000, reg_rdata_out});
		rd(can_filter_pkg::CONFIG2_ADDR, can_filter_pkg::CONFIG_RESET);
		wr(can_filter_pkg::MODE_UPPER_ADDR, 8'hFF);
		rd(can_filter_pkg::MODE_UPPER_ADDR, 8'h0F);
		wr(8'h40, 8'hA5);
		rd(8'h40, 8'h00);
		rd(can_filter_pkg::MODE_UPPER_ADDR, 8'h0F);
		// filters stay inactive while their bytes are loaded
		wr(can_filter_pkg::CONFIG2_ADDR, 8'h00);
		for (int f = 4; f < 6; f++)
			for (int k = 0; k < 8; k++)
				wr(can_filter_pkg::BANK_BASE_ADDR + 8'(8 * f + k), pat[k]);
		for (int f = 4; f < 6; f++)
			for (int k = 0; k < 8; k++)
				rd(can_filter_pkg::BANK_BASE_ADDR + 8'(8 * f + k), pat[k]);
		wr_rd(can_filter_pkg::BANK_BASE_ADDR + 8'(8 * 4), pat[0]);
		// every mode combination of filters 4 and 5, with filter 4, filter 5 or both active, never both inactive
		for (int c = 0; c < 4; c++) begin
			wr(can_filter_pkg::CONFIG2_ADDR, cfgs[c]);
			for (int m = 0; m < 16; m++) begin
				mv = 4'(m);
				wr(can_filter_pkg::MODE_UPPER_ADDR, {4'h0, mv});
				for (int i = 0; i < 5; i++) begin
					if (c < 3) begin
						h4 = cfgs[c][0] & (hit(1'b0, mv[0], ids[i][31:24]) | hit(1'b1, mv[1], ids[i][31:24]));
						h5 = cfgs[c][4] & (hit(1'b0, mv[2], ids[i][31:24]) | hit(1'b1, mv[3], ids[i][31:24]));
					end else begin
						h4 = hit_wide(1'b0, mv[1:0], ids[i]);
						h5 = hit_wide(1'b1, mv[3:2], ids[i]);
					end
					send_id(ids[i], {h5, h4, 4'h0});
				end
			end
		end
		print_verdict();
	end

	// a hang is cut short well after the roughly twelve hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clock_in);
		fail_count++;
		print_verdict();
	end
endmodule : can_acceptance_filter_bank_tb
